//--- common/ecr_consts.svh
// Constants for the echo canceller control and status register bank.
// Assumes byte-wide registers reached at their printed offsets.
`ifndef ECR_CONSTS_SVH
`define ECR_CONSTS_SVH

// Register offsets
`define ECR_ADDR_MAIN 8'h00
`define ECR_ADDR_LCTL 8'h01
`define ECR_ADDR_LSTAT 8'h02
`define ECR_ADDR_ACTL 8'h21
`define ECR_ADDR_ASTAT 8'h22

// Power-up values
`define ECR_RST_VAL 8'h00
`define ECR_ZERO_BYTE 8'h00

// Main control bit positions
`define ECR_MC_RESET 0
`define ECR_MC_HOWL 1
`define ECR_MC_AGC 2
`define ECR_MC_NB 3
`define ECR_MC_BYPASS 4
`define ECR_MC_MUTE_S 5
`define ECR_MC_MUTE_R 6
`define ECR_MC_SCALE 7

// Canceller control bit positions (shared by both cancellers)
`define ECR_CC_SUBBY 0
`define ECR_CC_FREEZE 1
`define ECR_CC_CLEAR 2
`define ECR_CC_OFFNULL 3
`define ECR_CC_NOISE 4
`define ECR_CC_SUPP 5
`define ECR_CC_SPEED 6
`define ECR_CC_TOP 7

// Preset walk: one step per control register
`define ECR_INIT_STEPS 3
`define ECR_IDX_MAIN 2'h0
`define ECR_IDX_LCTL 2'h1
`define ECR_IDX_ACTL 2'h2

`endif

//--- common/ecr_init_if.sv
// Link between the register bank and its preset sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface ecr_init_if;
    logic start; // Pulse: begin the preset walk
    logic busy; // Walk in progress
    ecr_pkg::ecr_idx_t index; // Register to preset while busy
    logic done; // Pulse: walk finished
    modport seq (input start, output busy, output index, output done);
    modport ctl (output start, input busy, input index, input done);
endinterface : ecr_init_if

//--- common/ecr_pkg.sv
// Types for the echo canceller control and status register bank.
// Assumes ecr_consts.svh is on the include path.
package ecr_pkg;
    // One register byte
    typedef logic [7:0] ecr_byte_t;
    // Index of the register being preset
    typedef logic [1:0] ecr_idx_t;
    // Preset sequencer states
    typedef enum logic [0:0] {ECR_IDLE, ECR_WALK} ecr_seq_t;
endpackage : ecr_pkg

//--- design/ecr_init_seq.sv
// Preset sequencer: walks the control registers one per cycle.
// Assumes start is a single-cycle pulse from the register bank.
`timescale 1ns/1ns
`include "ecr_consts.svh"
module ecr_init_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to the register bank
    ecr_init_if.seq init
);
    import ecr_pkg::*;

    // Whole state of the sequencer
    typedef struct packed {
        ecr_seq_t st;
        ecr_idx_t cnt;
        logic done;
    } ecr_seq_state_t;

    ecr_seq_state_t s_q; // Registered state
    ecr_seq_state_t s_d; // Next state

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        unique case (s_q.st)
            ECR_IDLE: begin
                // Start the walk at the first register
                if (init.start) begin
                    s_d.st = ECR_WALK;
                    s_d.cnt = `ECR_IDX_MAIN;
                end
            end
            ECR_WALK: begin
                // Last register preset, report completion
                if (s_q.cnt == 2'(`ECR_INIT_STEPS - 1)) begin
                    s_d.st = ECR_IDLE;
                    s_d.done = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 2'h1;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '{st: ECR_IDLE, cnt: `ECR_IDX_MAIN, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign init.busy = (s_q.st == ECR_WALK);
    assign init.index = s_q.cnt;
    assign init.done = s_q.done;
endmodule : ecr_init_seq

//--- design/ecr_regs.sv
// Control and status register bank of the dual echo canceller.
// Assumes the microport has already turned each access into one
// single-cycle read or write strobe with address and data.
// Functional notes
// - Main control bit 0 presets all three control registers
// - Reset bit clears itself when preset ends
// - Main bit 1 disables howling detector
// - Main bit 2 disables speaker gain control
// - Main bit 3 disables both narrowband detectors
// - Main bit 4 passes both paths through
// - Bits 5, 6 mute send, receive after suppressor
// - Main bit 7 enables two-bit shift mode
// - Shift needs both bits and 16-bit ports
// - Control bit 0 stops estimate subtraction
// - Control bit 1 freezes adaptation
// - Control bit 2 clears filter coefficients
// - Control bit 3 bypasses offset-nulling filter
// - Control bit 4 disables noise filtering
// - Control bit 5 disables residual suppressor
// - Control bit 6 disables adaptation speed control
// - Acoustic bit 7 disables exponential weighting
// - Status bit 0 shows send narrowband
// - Status bit 1 ORs both narrowband flags
// - Status bits 2, 3 show double-talk, suppressor
// - Status bits 5, 6 show howling, receive idle
// - Line status bit 0 shows receive narrowband
`timescale 1ns/1ns
`include "ecr_consts.svh"
module ecr_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register access from the microport
    input wire logic wr_en,
    input wire logic rd_en,
    input wire ecr_pkg::ecr_byte_t addr,
    input wire ecr_pkg::ecr_byte_t wdata,
    output logic [7:0] rdata,
    output logic rvalid,
    // Detector state
    input wire logic send_narrowband_det,
    input wire logic recv_narrowband_det,
    input wire logic double_talk_det,
    input wire logic suppressor_active_det,
    input wire logic howl_det,
    input wire logic receive_idle_det,
    // Port formats
    input wire logic send_linear16,
    input wire logic recv_linear16,
    // Main control outputs
    output logic howl_detect_off,
    output logic auto_gain_off,
    output logic narrowband_detect_off,
    output logic path_bypass,
    output logic send_mute,
    output logic recv_mute,
    output logic two_bit_scale,
    // Line canceller controls
    output logic line_estimate_subtract_bypass,
    output logic line_adaptation_freeze,
    output logic line_coefficient_clear,
    output logic line_offset_null_bypass,
    output logic line_noise_filter_off,
    output logic line_residual_suppressor_off,
    output logic line_adaptation_freeze_speed_ctrl_off,
    // Acoustic canceller controls
    output logic acou_estimate_subtract_bypass,
    output logic acou_adaptation_freeze,
    output logic acou_coefficient_clear,
    output logic acou_offset_null_bypass,
    output logic acou_noise_filter_off,
    output logic acou_residual_suppressor_off,
    output logic acou_adaptation_freeze_speed_ctrl_off,
    output logic acou_weighting_off
);
    import ecr_pkg::*;

    // Whole state of the bank
    typedef struct packed {
        ecr_byte_t main_control;
        ecr_byte_t line_canceller_control;
        ecr_byte_t acoustic_canceller_control;
        ecr_byte_t acoustic_canceller_status;
        ecr_byte_t line_canceller_status;
        ecr_byte_t rdata;
        logic rvalid;
        logic start;
        logic scale;
    } ecr_state_t;

    ecr_state_t s_q; // Registered state
    ecr_state_t s_d; // Next state
    ecr_init_if init (); // Link to the preset sequencer
    logic wr_ok; // Write accepted this cycle

    // Preset sequencer
    ecr_init_seq u_seq (
        .clk (clk),
        .rst_n (rst_n),
        .init (init)
    );

    // Writes are held off while the preset walk runs,
    // so a late write can never undo a preset step
    assign wr_ok = wr_en && !s_q.main_control[`ECR_MC_RESET];

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.rvalid = rd_en;
        // Status tracks the detectors every cycle
        s_d.acoustic_canceller_status = {1'b0, receive_idle_det, howl_det, 1'b0,
            suppressor_active_det, double_talk_det,
            send_narrowband_det | recv_narrowband_det,
            send_narrowband_det};
        s_d.line_canceller_status = {6'h00, send_narrowband_det | recv_narrowband_det,
            recv_narrowband_det};
        // Effective shift needs both enables and both ports linear
        s_d.scale = s_q.main_control[`ECR_MC_SCALE]
            && s_q.line_canceller_control[`ECR_CC_TOP]
            && send_linear16 && recv_linear16;
        // Register writes
        if (wr_ok) begin
            unique case (addr)
                `ECR_ADDR_MAIN: begin
                    if (wdata[`ECR_MC_RESET]) begin
                        // Preset requested, the other written bits are discarded
                        s_d.main_control[`ECR_MC_RESET] = 1'b1;
                        s_d.start = 1'b1;
                    end else begin
                        s_d.main_control = wdata;
                    end
                end
                `ECR_ADDR_LCTL: begin
                    s_d.line_canceller_control = wdata;
                end
                `ECR_ADDR_ACTL: begin
                    s_d.acoustic_canceller_control = wdata;
                end
                default: begin
                    // Status and unmapped offsets ignore writes
                end
            endcase
        end
        // Preset walk, one register per cycle
        if (init.busy) begin
            unique case (init.index)
                `ECR_IDX_MAIN: begin
                    s_d.main_control = `ECR_RST_VAL | 8'h01;
                end
                `ECR_IDX_LCTL: begin
                    s_d.line_canceller_control = `ECR_RST_VAL;
                end
                `ECR_IDX_ACTL: begin
                    s_d.acoustic_canceller_control = `ECR_RST_VAL;
                end
                default: begin
                    // No register at this index
                end
            endcase
        end
        // Reset bit drops on its own when the walk is done
        if (init.done) begin
            s_d.main_control[`ECR_MC_RESET] = 1'b0;
        end
        // Read data, unmapped offsets read zero
        if (rd_en) begin
            unique case (addr)
                `ECR_ADDR_MAIN: s_d.rdata = s_q.main_control;
                `ECR_ADDR_LCTL: s_d.rdata = s_q.line_canceller_control;
                `ECR_ADDR_LSTAT: s_d.rdata = s_q.line_canceller_status;
                `ECR_ADDR_ACTL: s_d.rdata = s_q.acoustic_canceller_control;
                `ECR_ADDR_ASTAT: s_d.rdata = s_q.acoustic_canceller_status;
                default: s_d.rdata = `ECR_ZERO_BYTE;
            endcase
        end
    end

    // State register; synchronous reset zeroes every register,
    // the read answer and the preset request together
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign init.start = s_q.start;

    // Bus answer
    assign rdata = s_q.rdata;
    assign rvalid = s_q.rvalid;

    // Main control outputs, straight from the register bits except two_bit_scale, which takes the gated shift
    assign howl_detect_off = s_q.main_control[`ECR_MC_HOWL];
    assign auto_gain_off = s_q.main_control[`ECR_MC_AGC];
    assign narrowband_detect_off = s_q.main_control[`ECR_MC_NB];
    assign path_bypass = s_q.main_control[`ECR_MC_BYPASS];
    assign send_mute = s_q.main_control[`ECR_MC_MUTE_S];
    assign recv_mute = s_q.main_control[`ECR_MC_MUTE_R];
    assign two_bit_scale = s_q.scale;

    // Line canceller controls
    assign line_estimate_subtract_bypass = s_q.line_canceller_control[`ECR_CC_SUBBY];
    assign line_adaptation_freeze = s_q.line_canceller_control[`ECR_CC_FREEZE];
    assign line_coefficient_clear = s_q.line_canceller_control[`ECR_CC_CLEAR];
    assign line_offset_null_bypass = s_q.line_canceller_control[`ECR_CC_OFFNULL];
    assign line_noise_filter_off = s_q.line_canceller_control[`ECR_CC_NOISE];
    assign line_residual_suppressor_off = s_q.line_canceller_control[`ECR_CC_SUPP];
    assign line_adaptation_freeze_speed_ctrl_off = s_q.line_canceller_control[`ECR_CC_SPEED];

    // Acoustic canceller controls
    assign acou_estimate_subtract_bypass = s_q.acoustic_canceller_control[`ECR_CC_SUBBY];
    assign acou_adaptation_freeze = s_q.acoustic_canceller_control[`ECR_CC_FREEZE];
    assign acou_coefficient_clear = s_q.acoustic_canceller_control[`ECR_CC_CLEAR];
    assign acou_offset_null_bypass = s_q.acoustic_canceller_control[`ECR_CC_OFFNULL];
    assign acou_noise_filter_off = s_q.acoustic_canceller_control[`ECR_CC_NOISE];
    assign acou_residual_suppressor_off = s_q.acoustic_canceller_control[`ECR_CC_SUPP];
    assign acou_adaptation_freeze_speed_ctrl_off = s_q.acoustic_canceller_control[`ECR_CC_SPEED];
    assign acou_weighting_off = s_q.acoustic_canceller_control[`ECR_CC_TOP];

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Reset bit stands five cycles, then drops
    reset_bit_self_a: assert property ($rose(s_q.main_control[0]) |->
        s_q.main_control[0] [*5] ##1 !s_q.main_control[0])
        else $error("reset bit did not self-clear on time");

    // Preset leaves main control at its default and the line freeze and acoustic weighting bits clear
    preset_values_a: assert property ($fell(s_q.main_control[0]) |->
        s_q.main_control == 8'h00 && line_adaptation_freeze == 1'b0
        && acou_weighting_off == 1'b0)
        else $error("preset left a control bit set");

    // Main control write reaches the outputs next cycle
    main_write_a: assert property (wr_ok && addr == 8'h00 && !wdata[0] |=>
        {recv_mute, send_mute, path_bypass, narrowband_detect_off, auto_gain_off,
        howl_detect_off} == $past(wdata[6:1]))
        else $error("main control outputs do not follow the write");

    // Shift only with both enables and both linear ports
    shift_gate_a: assert property (two_bit_scale |->
        $past(s_q.main_control[7] && s_q.line_canceller_control[7]
        && send_linear16 && recv_linear16))
        else $error("shift active without all conditions");

    // Acoustic control write lands on its outputs
    acou_write_a: assert property (wr_ok && addr == 8'h21 |=>
        acou_weighting_off == $past(wdata[7]) && acou_estimate_subtract_bypass == $past(wdata[0]))
        else $error("acoustic control outputs do not follow the write");

    // Combined narrowband flag reads back as the OR
    any_narrowband_a: assert property (##1 rd_en && addr == 8'h22 |=>
        rdata[1:0] == {$past(send_narrowband_det | recv_narrowband_det, 2),
        $past(send_narrowband_det, 2)})
        else $error("narrowband status read back wrong");

    // Reserved status bits stay low
    status_reserved_a: assert property (s_q.acoustic_canceller_status[7] == 1'b0
        && s_q.acoustic_canceller_status[4] == 1'b0 && s_q.line_canceller_status[7:2] == 6'h00)
        else $error("reserved status bit set");

    // Status bits follow detectors one cycle later
    // The cycle after reset is skipped: status was cleared, not sampled
    status_follow_a: assert property ($past(rst_n) |->
        s_q.acoustic_canceller_status[6:5] == $past({receive_idle_det, howl_det})
        && s_q.acoustic_canceller_status[3:2] == $past({suppressor_active_det, double_talk_det})
        && s_q.line_canceller_status[0] == $past(recv_narrowband_det))
        else $error("status does not track the detectors");

    // Every read is answered next cycle for one cycle
    read_answer_a: assert property (rd_en |=> rvalid)
        else $error("read not answered");

    // Answer lasts one cycle unless another read follows
    read_single_a: assert property (!rd_en |=> !rvalid)
        else $error("read answer stands too long");

    // Line control write lands on its outputs
    line_write_a: assert property (wr_ok && addr == `ECR_ADDR_LCTL |=>
        {line_adaptation_freeze_speed_ctrl_off, line_residual_suppressor_off, line_noise_filter_off,
        line_offset_null_bypass, line_coefficient_clear, line_adaptation_freeze,
        line_estimate_subtract_bypass} == $past(wdata[6:0]))
        else $error("line control outputs do not follow the write");

    // Reset write raises the reset bit next cycle
    reset_write_a: assert property (wr_ok && addr == `ECR_ADDR_MAIN
        && wdata[`ECR_MC_RESET] |=> s_q.main_control[`ECR_MC_RESET])
        else $error("reset write did not start the preset");

    // Preset step clears the line control register
    preset_line_a: assert property (init.busy && init.index == `ECR_IDX_LCTL |=>
        s_q.line_canceller_control == `ECR_RST_VAL)
        else $error("preset step left line control set");

    // All shift conditions met turn the shift on next cycle
    shift_on_a: assert property (s_q.main_control[`ECR_MC_SCALE] && send_linear16
        && s_q.line_canceller_control[`ECR_CC_TOP] && recv_linear16 |=> two_bit_scale)
        else $error("shift stays off with all conditions met");
endmodule : ecr_regs

//--- testbench/ecr_host_model.sv
// Host side of the register port: issues single-cycle strobes.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ns
`include "ecr_consts.svh"
module ecr_host_model (
    // Clock
    clk,
    // Register strobes toward the bank
    wr_en,
    rd_en,
    addr,
    wdata
);
    import ecr_pkg::*;
    input wire logic clk;
    output logic wr_en;
    output logic rd_en;
    output ecr_pkg::ecr_byte_t addr;
    output ecr_pkg::ecr_byte_t wdata;
    // Idle bus at time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // One write; the acoustic status register is never written
    task automatic write_reg(input ecr_byte_t a, input ecr_byte_t d);
        if (a != `ECR_ADDR_ASTAT) begin
            @(posedge clk);
            wr_en <= 1'b1;
            addr <= a;
            wdata <= d;
            @(posedge clk);
            wr_en <= 1'b0;
            // Stale lines show garbage, not the old value
            addr <= ~a;
            wdata <= ~d;
        end
    endtask : write_reg
    // One read strobe; the answer is watched by the bench
    task automatic read_reg(input ecr_byte_t a);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        addr <= ~a;
    endtask : read_reg
endmodule : ecr_host_model

//--- testbench/tb_echo_canceller_control_status_regs.sv
// Self-checking bench for the echo canceller register bank.
// Assumes the host model drives the strobes and the bench the detectors.
`timescale 1ns/1ns
`include "ecr_consts.svh"
module tb_echo_canceller_control_status_regs;
    import ecr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en, rd_en, rvalid;
    ecr_byte_t addr, wdata;
    logic [7:0] rdata;
    logic [5:0] det = 6'h00; // idle, howl, supp, dt, rnb, snb
    logic [1:0] lin = 2'h0; // Port formats
    logic [6:0] m_o, l_o;
    logic [7:0] a_o;
    ecr_byte_t exp_q[$]; // Expected read answers
    int mismatches = 0;
    int checks = 0;
    int seed;
    ecr_byte_t mc, lc, ac;
    // 125 MHz clock
    always #4 clk = ~clk;
    ecr_host_model ecr_host_model_i (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata));
    ecr_regs ecr_regs_i (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
        .send_narrowband_det(det[0]), .recv_narrowband_det(det[1]),
        .double_talk_det(det[2]), .suppressor_active_det(det[3]), .howl_det(det[4]),
        .receive_idle_det(det[5]), .send_linear16(lin[0]), .recv_linear16(lin[1]),
        .howl_detect_off(m_o[0]), .auto_gain_off(m_o[1]), .narrowband_detect_off(m_o[2]),
        .path_bypass(m_o[3]), .send_mute(m_o[4]), .recv_mute(m_o[5]),
        .two_bit_scale(m_o[6]),
        .line_estimate_subtract_bypass(l_o[0]), .line_adaptation_freeze(l_o[1]),
        .line_coefficient_clear(l_o[2]), .line_offset_null_bypass(l_o[3]),
        .line_noise_filter_off(l_o[4]), .line_residual_suppressor_off(l_o[5]),
        .line_adaptation_freeze_speed_ctrl_off(l_o[6]),
        .acou_estimate_subtract_bypass(a_o[0]), .acou_adaptation_freeze(a_o[1]),
        .acou_coefficient_clear(a_o[2]), .acou_offset_null_bypass(a_o[3]),
        .acou_noise_filter_off(a_o[4]), .acou_residual_suppressor_off(a_o[5]),
        .acou_adaptation_freeze_speed_ctrl_off(a_o[6]), .acou_weighting_off(a_o[7]));
    // Byte comparison for read answers
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : cmp_byte
    // Control outputs against the three register images
    task automatic cmp_ctl(input ecr_byte_t m, input ecr_byte_t l, input ecr_byte_t a);
        logic [6:0] m_e;
        m_e = {m[7] & l[7] & lin[0] & lin[1], m[6:1]};
        @(posedge clk);
        @(posedge clk);
        #1;
        checks++;
        if ({m_o, l_o, a_o} !== {m_e, l[6:0], a}) begin
            mismatches++;
            $display("mismatch at %0t: controls %h expected %h", $time, {m_o, l_o, a_o},
                {m_e, l[6:0], a});
        end
    endtask : cmp_ctl
    // Note the expected answer, then issue the read
    task automatic rd(input ecr_byte_t a, input ecr_byte_t e);
        exp_q.push_back(e);
        ecr_host_model_i.read_reg(a);
    endtask : rd
    // Write all three control registers
    task automatic wr3(input ecr_byte_t m, input ecr_byte_t l, input ecr_byte_t a);
        ecr_host_model_i.write_reg(`ECR_ADDR_MAIN, m);
        ecr_host_model_i.write_reg(`ECR_ADDR_LCTL, l);
        ecr_host_model_i.write_reg(`ECR_ADDR_ACTL, a);
    endtask : wr3
    // Monitor: each answer takes the oldest note
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("mismatch at %0t: answer without a read", $time);
            end else begin
                cmp_byte(rdata, exp_q.pop_front());
            end
        end
    end
    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // Watchdog well past the expected run length
    initial begin
        #400000;
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test();
    end
    // Main sequence
    initial begin
        seed = 32'h9419;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Power-up values, unmapped read is zero
        cmp_ctl(8'h00, 8'h00, 8'h00);
        rd(`ECR_ADDR_MAIN, 8'h00);
        rd(`ECR_ADDR_LCTL, 8'h00);
        rd(`ECR_ADDR_ACTL, 8'h00);
        rd(`ECR_ADDR_ASTAT, 8'h00);
        rd(8'h33, 8'h00);
        $display("test power_up done");
        // Walking one through every control bit except main bit 0
        lin <= 2'h3;
        for (int i = 0; i < 8; i++) begin
            mc = 8'h01 << i;
            mc[0] = 1'b0;
            wr3(mc, 8'h01 << i, 8'h01 << i);
            cmp_ctl(mc, 8'h01 << i, 8'h01 << i);
            cmp_ctl(mc, 8'h01 << i, 8'h01 << i);
        end
        $display("test walking_bits done");
        // Every combination of the four shift conditions
        for (int j = 0; j < 16; j++) begin
            lin <= j[1:0];
            wr3({j[3], 7'h00}, {j[2], 7'h00}, 8'h00);
            cmp_ctl({j[3], 7'h00}, {j[2], 7'h00}, 8'h00);
        end
        $display("test shift_mode done");
        // Random images, detectors and readback
        for (int k = 0; k < 8; k++) begin
            mc = 8'($random(seed));
            mc[0] = 1'b0;
            lc = 8'($random(seed));
            ac = 8'($random(seed));
            lin <= 2'($random(seed));
            det <= 6'($random(seed));
            wr3(mc, lc, ac);
            ecr_host_model_i.write_reg(8'h10, 8'($random(seed)));
            cmp_ctl(mc, lc, ac);
            rd(`ECR_ADDR_MAIN, mc);
            rd(`ECR_ADDR_LCTL, lc);
            rd(`ECR_ADDR_ACTL, ac);
            rd(`ECR_ADDR_ASTAT, {1'b0, det[5:4], 1'b0, det[3:2], det[0] | det[1],
                det[0]});
            rd(`ECR_ADDR_LSTAT, {6'h00, det[0] | det[1], det[1]});
        end
        $display("test random_access done");
        // Mid-run reset clears the random images
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        cmp_ctl(8'h00, 8'h00, 8'h00);
        rd(`ECR_ADDR_LCTL, 8'h00);
        rd(`ECR_ADDR_MAIN, 8'h00);
        $display("test mid_reset done");
        // Software reset presets and clears itself
        wr3(8'hfe, 8'hff, 8'hff);
        ecr_host_model_i.write_reg(`ECR_ADDR_MAIN, 8'hff);
        // Old bits stand until the walk presets them; the reset bit reads one
        rd(`ECR_ADDR_MAIN, 8'hff);
        // A write during the walk is dropped
        ecr_host_model_i.write_reg(`ECR_ADDR_LCTL, 8'h55);
        repeat (8) @(posedge clk);
        rd(`ECR_ADDR_MAIN, 8'h00);
        rd(`ECR_ADDR_LCTL, 8'h00);
        rd(`ECR_ADDR_ACTL, 8'h00);
        lin <= 2'h3;
        cmp_ctl(8'h00, 8'h00, 8'h00);
        $display("test soft_reset done");
        repeat (3) @(posedge clk);
        if (exp_q.size() != 0) begin
            mismatches++;
            $display("mismatch at %0t: reads left unanswered", $time);
        end
        end_of_test();
    end
endmodule : tb_echo_canceller_control_status_regs
